/* pkg/flash_guard_pkg.sv */
// constants shared by the overlay map, the error guard and the register top
`default_nettype none
package flash_guard_pkg;
	// ==============================
	// bus widths
	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	localparam int IDX_W = 22;
	// ==============================
	// register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_OVERLAY_CTRL = 22'h0ee077;
	localparam logic [IDX_W-1:0] IDX_FLASH_STATUS = 22'h0ee07d;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 22'h0ee078;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 22'h0ee079;
	localparam logic [1:0] WORD_ALIGN = 2'h0;
	// ==============================
	// field positions
	localparam int EMUL_BIT = 3;
	localparam int WIN_HI_BIT = 2;
	localparam int WIN_LO_BIT = 1;
	localparam int WIN_EXTRA_BIT = 0;
	localparam int FLAG_BIT = 7;
	localparam logic [7:0] OVERLAY_RESET = 8'hf0;
	localparam logic [7:0] OVERLAY_FIXED = 8'hf0;
	localparam logic [7:0] OVERLAY_LIVE = 8'h0f;
	localparam logic [7:0] OVERLAY_WATCH = 8'h0e;
	localparam logic [7:0] STATUS_FIXED = 8'h7f;
	// ==============================
	// interrupt status layout
	localparam int IRQ_W = 2;
	localparam int IRQ_ERR_BIT = 0;
	localparam int IRQ_MODE6_BIT = 1;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
	// ==============================
	// address map, in 1 KB pages
	localparam int PAGE_LSB = 10;
	localparam int PAGE_W = ADDR_W - PAGE_LSB;
	localparam logic [PAGE_W-1:0] NORMAL_RAM_PAGE = 14'h3ffc;
	localparam int WIN_LSB = 12;
	localparam logic [ADDR_W-WIN_LSB-1:0] WIN_REGION = 12'h000;
	// ==============================
	// operating modes
	typedef enum logic [2:0] {
		MODE_NONE = 3'h0,
		MODE_ONE = 3'h1,
		MODE_FIVE = 3'h5,
		MODE_SINGLE_NORMAL = 3'h6,
		MODE_SEVEN = 3'h7
	} op_mode_t;
	typedef enum logic {
		GUARD_CLEAR = 1'b0,
		GUARD_LOCKED = 1'b1
	} guard_state_t;
endpackage
`default_nettype wire

/* rtl/overlay_map.sv */
// address decode that places on-chip ram at its normal page or over a flash window
`default_nettype none
module overlay_map import flash_guard_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rstSync_b,
	input wire logic ce,
	// overlay control
	input wire logic emulOn,
	input wire logic [1:0] window,
	// cpu access
	input wire logic cpuValid,
	input wire logic [ADDR_W-1:0] cpuAddr,
	// routing
	output logic flashHit,
	output logic ramSel,
	output logic flashSel,
	output logic [PAGE_LSB-1:0] ramOffset
);
	// ==============================
	// decode
	wire logic [PAGE_W-1:0] page = cpuAddr[ADDR_W-1:PAGE_LSB];
	wire logic inWindowRegion = (cpuAddr[ADDR_W-1:WIN_LSB] == WIN_REGION);
	wire logic inWindow = inWindowRegion && (cpuAddr[WIN_LSB-1:PAGE_LSB] == window);
	wire logic normalHit = !emulOn && (page == NORMAL_RAM_PAGE);
	wire logic emulHit = emulOn && inWindow;
	wire logic ramHit = cpuValid && (normalHit || emulHit);
	// flash region is everything that is neither ram page; finer map lives elsewhere
	assign flashHit = cpuValid && !ramHit && (page != NORMAL_RAM_PAGE);
	// ==============================
	// registered routing
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			ramSel <= 1'b0;
			flashSel <= 1'b0;
			ramOffset <= '0;
		end else if (ce) begin
			ramSel <= ramHit;
			flashSel <= flashHit;
			ramOffset <= cpuAddr[PAGE_LSB-1:0];
		end
	end
	// ==============================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstSync_b);
	normal_ram_page_a: assert property (ce && cpuValid && !emulOn && page == NORMAL_RAM_PAGE
		|=> ramSel && !flashSel) else $error("normal ram page not routed to ram");
	window_steer_a: assert property (ce && cpuValid && emulOn && inWindowRegion
		|=> ramSel == $past(inWindow)) else $error("flash window steering wrong");
	window_not_flash_a: assert property (ce && emulHit && cpuValid
		|=> !flashSel) else $error("window access reached flash");
endmodule
`default_nettype wire

/* rtl/error_guard.sv */
// program/erase error flag with its protection output
`default_nettype none
module error_guard import flash_guard_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rstSync_b,
	input wire logic ce,
	// conditions
	input wire logic progActive,
	input wire logic flashRead,
	input wire logic excStart,
	input wire logic excExempt,
	input wire logic sleepExec,
	input wire logic busRelease,
	input wire logic wdtReset,
	input wire logic hwStandby,
	// results
	output logic errorFlag,
	output logic protectOn,
	output logic errorSet,
	output logic stackReady
);
	guard_state_t state;
	guard_state_t next_state;
	// ==============================
	// set and clear terms
	wire logic excHit = excStart && !excExempt;
	wire logic setTerm = progActive && (flashRead || excHit || sleepExec || busRelease);
	wire logic clearTerm = wdtReset || hwStandby;
	// stacking waits one cycle so the flag is set before the vector fetch
	assign stackReady = !(progActive && excHit && state == GUARD_CLEAR);
	assign errorSet = setTerm && !clearTerm && state == GUARD_CLEAR;
	always_comb begin
		next_state = state;
		case (state)
			GUARD_CLEAR: begin
				if (setTerm && !clearTerm) next_state = GUARD_LOCKED;
			end
			GUARD_LOCKED: begin
				if (clearTerm) next_state = GUARD_CLEAR;
			end
			default: next_state = GUARD_CLEAR;
		endcase
	end
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) state <= GUARD_CLEAR;
		else if (ce) state <= next_state;
	end
	assign errorFlag = (state == GUARD_LOCKED);
	assign protectOn = (state == GUARD_LOCKED);
	// ==============================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstSync_b);
	read_sets_flag_a: assert property (ce && progActive && flashRead && !clearTerm
		|=> errorFlag) else $error("flash read during program did not set flag");
	exempt_exc_a: assert property (ce && !errorFlag && excStart && excExempt && !flashRead
		&& !sleepExec && !busRelease |=> !errorFlag) else $error("exempt exception set flag");
	// a watchdog or standby clear in the same cycle wins, so it is left out here
	stack_after_flag_a: assert property (ce && !stackReady && !clearTerm
		|=> errorFlag && stackReady) else $error("stacking not held for flag");
	sleep_bus_flag_a: assert property (ce && progActive && (sleepExec || busRelease)
		&& !clearTerm |=> errorFlag) else $error("sleep or bus release missed");
	protect_follows_a: assert property (ce && errorSet |=> protectOn)
		else $error("protection not raised by error");
	flag_clear_only_a: assert property (errorFlag && !(ce && clearTerm) |=> errorFlag)
		else $error("flag cleared without reset or standby");
	clear_wins_a: assert property (ce && clearTerm |=> !errorFlag)
		else $error("clear condition left flag set");
endmodule
`default_nettype wire

/* rtl/flash_ram_emulation_and_error_guard.sv */
// register top: apb slave, overlay control, error status and interrupt
//
// The APB interface to the registers was left to the implementer.
`default_nettype none
module flash_ram_emulation_and_error_guard import flash_guard_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins
	input wire logic [2:0] opModePin,
	input wire logic hwStandbyPin,
	// cpu side events
	input wire logic progActive,
	input wire logic cpuValid,
	input wire logic cpuRead,
	input wire logic [ADDR_W-1:0] cpuAddr,
	input wire logic excStart,
	input wire logic excExempt,
	input wire logic sleepExec,
	input wire logic busRelease,
	input wire logic wdtReset,
	// results
	output logic ramSel,
	output logic flashSel,
	output logic [PAGE_LSB-1:0] ramOffset,
	output logic readUndefined,
	output logic protectOn,
	output logic stackReady,
	output logic irq
);
	// ==============================
	// reset release and pin synchronisers
	logic rstMeta_b;
	logic rstSync_b;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_b <= 1'b0;
			rstSync_b <= 1'b0;
		end else begin
			rstMeta_b <= 1'b1;
			rstSync_b <= rstMeta_b;
		end
	end
	logic [3:0] pinMeta;
	logic [3:0] pinSync;
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			pinMeta <= 4'h0;
			pinSync <= 4'h0;
		end else if (ce) begin
			pinMeta <= {hwStandbyPin, opModePin};
			pinSync <= pinMeta;
		end
	end
	wire logic hwStandby = pinSync[3];
	wire logic [2:0] opMode = pinSync[2:0];
	// mode is treated as a strap; writability follows the synchronised copy
	wire logic modeWritable = (opMode >= MODE_FIVE);
	wire logic modeSingleNormal = (opMode == MODE_SINGLE_NORMAL);
	// ==============================
	// apb decode
	wire logic setupPhase = psel && !penable;
	wire logic accessPhase = psel && penable;
	wire logic aligned = (paddr[1:0] == WORD_ALIGN);
	wire logic [IDX_W-1:0] idx = paddr[ADDR_W-1:2];
	wire logic hitOverlay = aligned && (idx == IDX_OVERLAY_CTRL);
	wire logic hitStatus = aligned && (idx == IDX_FLASH_STATUS);
	wire logic hitIrqStatus = aligned && (idx == IDX_IRQ_STATUS);
	wire logic hitIrqMask = aligned && (idx == IDX_IRQ_MASK);
	wire logic mapped = hitOverlay || hitStatus || hitIrqStatus || hitIrqMask;
	// zero wait state; a frozen block holds the access phase
	assign pready = ce;
	wire logic wrStrobe = ce && accessPhase && pwrite && mapped;
	wire logic wrOverlay = wrStrobe && hitOverlay && modeWritable;
	wire logic wrIrqStatus = wrStrobe && hitIrqStatus;
	wire logic wrIrqMask = wrStrobe && hitIrqMask;
	// ==============================
	// overlay control register
	logic [3:0] overlayBits;
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) overlayBits <= OVERLAY_RESET[3:0];
		else if (wrOverlay) overlayBits <= pwdata[3:0];
	end
	wire logic [7:0] overlayRead = OVERLAY_FIXED | {4'h0, overlayBits};
	wire logic emulOn = overlayBits[EMUL_BIT];
	wire logic [1:0] window = {overlayBits[WIN_HI_BIT], overlayBits[WIN_LO_BIT]};
	// mode 6 emulation is unsupported; flag software that tries it
	wire logic mode6Misuse = wrOverlay && modeSingleNormal
		&& ((pwdata[7:0] & OVERLAY_WATCH) != 8'h00);
	// ==============================
	// overlay map
	logic flashHit;
	overlay_map u_map (
		.clk(clk),
		.rstSync_b(rstSync_b),
		.ce(ce),
		.emulOn(emulOn),
		.window(window),
		.cpuValid(cpuValid),
		.cpuAddr(cpuAddr),
		.flashHit(flashHit),
		.ramSel(ramSel),
		.flashSel(flashSel),
		.ramOffset(ramOffset)
	);
	// ram overlay reads are exempt because they never reach flashHit
	wire logic flashRead = flashHit && cpuRead;
	// ==============================
	// error guard
	logic errorFlag;
	logic errorSet;
	error_guard u_guard (
		.clk(clk),
		.rstSync_b(rstSync_b),
		.ce(ce),
		.progActive(progActive),
		.flashRead(flashRead),
		.excStart(excStart),
		.excExempt(excExempt),
		.sleepExec(sleepExec),
		.busRelease(busRelease),
		.wdtReset(wdtReset),
		.hwStandby(hwStandby),
		.errorFlag(errorFlag),
		.protectOn(protectOn),
		.errorSet(errorSet),
		.stackReady(stackReady)
	);
	wire logic [7:0] statusRead = STATUS_FIXED | {errorFlag, 7'h00};
	// ==============================
	// undefined read marker
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) readUndefined <= 1'b0;
		else if (ce) readUndefined <= flashRead && progActive;
	end
	// ==============================
	// interrupt status and mask
	logic [IRQ_W-1:0] irqStatus;
	logic [IRQ_W-1:0] irqMask;
	logic [IRQ_W-1:0] irqEvent;
	logic [IRQ_W-1:0] irqClear;
	logic [IRQ_W-1:0] next_irqStatus;
	assign irqEvent[IRQ_ERR_BIT] = ce && errorSet;
	assign irqEvent[IRQ_MODE6_BIT] = mode6Misuse;
	assign irqClear = wrIrqStatus ? pwdata[IRQ_W-1:0] : IRQ_RESET;
	// an event in the clearing cycle survives the write of one
	assign next_irqStatus = (irqStatus & ~irqClear) | irqEvent;
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			irqStatus <= IRQ_RESET;
			irqMask <= IRQ_RESET;
		end else if (ce) begin
			irqStatus <= next_irqStatus;
			if (wrIrqMask) irqMask <= pwdata[IRQ_W-1:0];
		end
	end
	assign irq = |(irqStatus & irqMask);
	// ==============================
	// read mux, captured in the setup cycle
	logic [7:0] readByte;
	assign readByte = hitOverlay ? overlayRead :
		hitStatus ? statusRead :
		hitIrqStatus ? {6'h00, irqStatus} :
		hitIrqMask ? {6'h00, irqMask} : 8'h00;
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (ce && setupPhase) begin
			prdata <= {24'h000000, readByte};
			pslverr <= !mapped;
		end
	end
	// ==============================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstSync_b);
	sequence setup_s;
		ce && setupPhase;
	endsequence
	sequence read_status_s;
		setup_s and (hitStatus && !pwrite);
	endsequence
	status_read_a: assert property (read_status_s |=> prdata[7:0] == {$past(errorFlag), 7'h7f})
		else $error("status read does not show flag");
	unmapped_err_a: assert property (setup_s and !mapped |=> pslverr)
		else $error("unmapped address gave no error");
	overlay_locked_a: assert property (ce && accessPhase && pwrite && hitOverlay
		&& !modeWritable |=> $stable(overlayBits)) else $error("overlay written in mode 1 to 4");
	mode6_flag_a: assert property (mode6Misuse |=> irqStatus[IRQ_MODE6_BIT])
		else $error("mode 6 misuse not reported");
	write_no_clear_a: assert property (ce && accessPhase && pwrite && hitStatus && errorFlag
		&& !wdtReset && !hwStandby |=> errorFlag) else $error("status write cleared flag");
	set_beats_clear_a: assert property (irqEvent[IRQ_ERR_BIT] |=> irqStatus[IRQ_ERR_BIT])
		else $error("error event lost");
	irq_level_a: assert property (irqEvent[IRQ_ERR_BIT] && irqMask[IRQ_ERR_BIT] && !wrIrqMask
		|=> irq) else $error("interrupt level mismatch");
	undef_mark_a: assert property (ce && flashRead && progActive |=> readUndefined)
		else $error("undefined read not marked");
endmodule
`default_nettype wire

/* test/cpu_bus_model.sv */
// cpu bus model that presents accesses to the block one cycle after request
`default_nettype none
module cpu_bus_model (
	// clock
	input wire logic clk,
	// request from the bench
	input wire logic reqV,
	input wire logic reqR,
	input wire logic [23:0] reqA,
	// cpu bus
	output logic cpuValid,
	output logic cpuRead,
	output logic [23:0] cpuAddr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cpuValid = 1'b0;
		cpuRead = 1'b0;
		cpuAddr = 24'h000000;
	end
	// idle bus shows the inverse of the last value, so stale data never looks valid
	always @(posedge clk) begin
		cpuValid <= reqV;
		cpuAddr <= reqV ? reqA : ~cpuAddr;
		cpuRead <= reqV ? reqR : ~cpuRead;
	end
endmodule
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the overlay map and the error guard
`default_nettype none
module tb import flash_guard_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ==============================
	// signals
	logic clk = 0, rst_b = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic pready, pslverr, ramSel, flashSel, readUndefined, protectOn, stackReady, irq;
	logic [PAGE_LSB-1:0] ramOffset;
	logic [2:0] opModePin = 3'h7;
	logic hwStandbyPin = 0, progActive = 0, excStart = 0, excExempt = 0;
	logic sleepExec = 0, busRelease = 0, wdtReset = 0;
	logic cpuValid, cpuRead, reqV = 0, reqR = 0, vd = 0, emul = 0;
	logic [23:0] cpuAddr, reqA = '0;
	logic [1:0] win = 0;
	logic [31:0] seed = 32'd2167;
	logic [8:0] qa[$];
	logic [12:0] qc[$];
	int errTotal = 0, samplesChecked = 0;
	always #2.5 clk = ~clk;
	flash_ram_emulation_and_error_guard i_flash_ram_emulation_and_error_guard (.clk, .rst_b,
		.ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .opModePin,
		.hwStandbyPin, .progActive, .cpuValid, .cpuRead, .cpuAddr, .excStart, .excExempt,
		.sleepExec, .busRelease, .wdtReset, .ramSel, .flashSel, .ramOffset, .readUndefined,
		.protectOn, .stackReady, .irq);
	cpu_bus_model i_cpu_bus_model (.clk, .reqV, .reqR, .reqA, .cpuValid, .cpuRead, .cpuAddr);
	// ==============================
	// helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		samplesChecked++;
		if (s !== e) begin
			errTotal++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic giveVerdict();
		// notes still queued at the end were never answered
		errTotal += qa.size() + qc.size();
		$display("checks %0d mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [IDX_W-1:0] ix, input logic [8:0] e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {ix, WORD_ALIGN};
		pwdata <= {24'h0, e[7:0]};
		if (!w)
			qa.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic cpu(input logic [23:0] a, input logic r);
		logic rm, np, fl;
		np = a[23:PAGE_LSB] == NORMAL_RAM_PAGE;
		rm = emul ? a[23:PAGE_LSB] == {12'h0, win} : np;
		fl = !rm && !np;
		qc.push_back({rm, fl, progActive & r & fl, a[9:0]});
		reqV <= 1'b1;
		reqA <= a;
		reqR <= r;
		@(posedge clk);
		reqV <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic pulse(input logic [3:0] k);
		logic ex;
		{excStart, sleepExec, busRelease, wdtReset} <= k;
		// look inside the cycle in which the exception starts, before its edge
		#1;
		ex = k[3] && progActive && !excExempt && !protectOn;
		if (ex)
			chk("stackReady", 0, stackReady);
		@(posedge clk);
		#1;
		if (ex)
			chk("protectOn", 1, protectOn);
		if (ex)
			chk("stackReady", 1, stackReady);
		@(posedge clk);
		{excStart, sleepExec, busRelease, wdtReset} <= 4'h0;
		repeat (2) @(posedge clk);
	endtask
	// ==============================
	// result watcher
	always @(posedge clk) begin
		vd <= cpuValid;
		if (vd && qc.size() > 0)
			chk("cpu map", qc.pop_front(), {ramSel, flashSel, readUndefined, ramOffset});
		if (psel && penable && pready && !pwrite && qa.size() > 0) begin
			if (qa[0][8])
				chk("pslverr", 1, pslverr);
			else
				chk("prdata", qa[0], {pslverr, prdata[7:0]});
			void'(qa.pop_front());
		end
	end
	initial begin
		#60000;
		errTotal++;
		giveVerdict();
	end
	// ==============================
	// scenarios
	initial begin
		logic [1:0] w;
		logic [9:0] o;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (5) @(posedge clk);
		apb(0, IDX_OVERLAY_CTRL, 9'h0f0);
		apb(0, IDX_FLASH_STATUS, 9'h07f);
		apb(0, IDX_IRQ_MASK, 9'h000);
		apb(0, 22'h000001, 9'h100);
		for (int i = 0; i < 4; i++) begin
			w = 2'(i);
			o = 10'(rnd());
			apb(1, IDX_OVERLAY_CTRL, {5'h1, w, o[0]});
			apb(0, IDX_OVERLAY_CTRL, {5'h1f, w, o[0]});
			emul = 1;
			win = w;
			cpu({12'h0, w, o}, o[1]);
			cpu({14'h3ffc, o}, 0);
			cpu({12'h0, w + 2'h1, o}, 1);
		end
		apb(1, IDX_OVERLAY_CTRL, 9'h006);
		emul = 0;
		cpu({14'h3ffc, o}, 1);
		cpu(24'h000c00 | o, 1);
		opModePin <= 3'h1;
		repeat (4) @(posedge clk);
		apb(1, IDX_OVERLAY_CTRL, 9'h008);
		apb(0, IDX_OVERLAY_CTRL, 9'h0f6);
		opModePin <= 3'h6;
		repeat (4) @(posedge clk);
		apb(1, IDX_OVERLAY_CTRL, 9'h00e);
		apb(0, IDX_OVERLAY_CTRL, 9'h0fe);
		apb(0, IDX_IRQ_STATUS, 9'h002);
		apb(1, IDX_IRQ_STATUS, 9'h002);
		opModePin <= 3'h7;
		repeat (4) @(posedge clk);
		emul = 1;
		win = 3;
		progActive <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			apb(1, IDX_IRQ_MASK, {8'h0, k != 3});
			if (k == 0)
				cpu(24'h010000 | (24'(rnd()) & 24'h3ff), 1);
			else
				pulse(4'h1 << (4 - k));
			apb(0, IDX_FLASH_STATUS, 9'h0ff);
			chk("protectOn", 1, protectOn);
			chk("irq", k != 3, irq);
			apb(1, IDX_FLASH_STATUS, 9'h000);
			apb(0, IDX_FLASH_STATUS, 9'h0ff);
			pulse(4'h1);
			apb(0, IDX_FLASH_STATUS, 9'h07f);
			chk("protectOn", 0, protectOn);
			apb(0, IDX_IRQ_STATUS, 9'h001);
			apb(1, IDX_IRQ_STATUS, 9'h001);
			chk("irq", 0, irq);
		end
		excExempt <= 1'b1;
		pulse(4'h8);
		excExempt <= 1'b0;
		cpu(24'h000c00 | (24'(rnd()) & 24'h3ff), 1);
		apb(0, IDX_FLASH_STATUS, 9'h07f);
		pulse(4'h2);
		hwStandbyPin <= 1'b1;
		repeat (4) @(posedge clk);
		hwStandbyPin <= 1'b0;
		repeat (4) @(posedge clk);
		apb(0, IDX_FLASH_STATUS, 9'h07f);
		// reset pin in mid-run clears a set flag and the overlay control
		pulse(4'h2);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (5) @(posedge clk);
		emul = 0;
		apb(0, IDX_FLASH_STATUS, 9'h07f);
		apb(0, IDX_OVERLAY_CTRL, 9'h0f0);
		progActive <= 1'b0;
		pulse(4'h4);
		apb(0, IDX_FLASH_STATUS, 9'h07f);
		repeat (4) @(posedge clk);
		giveVerdict();
	end
endmodule
`default_nettype wire
